// File: inc/pmcfg_defines.vh
// register offsets, field layouts, reset values and timing constants of the output config bank
`ifndef PMCFG_DEFINES_VH
`define PMCFG_DEFINES_VH

// ----------------------------------------------------------------
// command codes
// ----------------------------------------------------------------
`define PMCFG_CMD_SEQ_POS 8'hD5
`define PMCFG_CMD_MODE 8'hD6
`define PMCFG_CMD_DIV_PHASE 8'hD7
`define PMCFG_CMD_VREF 8'hD8
`define PMCFG_CMD_ILIM 8'hD9

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMCFG_START_LSB 0
`define PMCFG_STOP_LSB 2
`define PMCFG_CCM_BIT 0
`define PMCFG_SHARE_BIT 1
`define PMCFG_DIV_LSB 0
`define PMCFG_PHASE_LSB 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMCFG_SEQ_RST 4'h0
`define PMCFG_CCM_RST 1'b0
`define PMCFG_DIV_RST 2'h0
`define PMCFG_PHASE_RST0 5'h00
`define PMCFG_PHASE_RST1 5'h02
`define PMCFG_PHASE_RST2 5'h01
`define PMCFG_PHASE_RST3 5'h03
`define PMCFG_VREF_RST 7'h14
`define PMCFG_ILIM_HI_RST 3'h4
`define PMCFG_ILIM_LO_RST 3'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMCFG_CLK_MHZ 200
`define PMCFG_BLANK_US 100
`define PMCFG_BLANK_CYCLES (`PMCFG_BLANK_US * `PMCFG_CLK_MHZ)
`define PMCFG_STEP_NS 1000
`define PMCFG_STEP_CYCLES ((`PMCFG_STEP_NS * `PMCFG_CLK_MHZ) / 1000)

`endif

// File: design/pmcfg_bank.v
// per-output paged configuration bank with sequencer, reference slew and fault blanking
`timescale 1ns/1ps
`include "pmcfg_defines.vh"
module pmcfg_bank #(
  parameter BLANK_CYCLES = `PMCFG_BLANK_CYCLES
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // command port
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire [1:0] cmdPage,
  input wire [7:0] cmdWrData,
  output reg [7:0] cmdRdData,
  output reg cmdRdValid,
  // sequencing
  input wire seqStartReq,
  input wire seqStopReq,
  input wire powerGoodGatingSelect,
  input wire [3:0] powerGoodStatus,
  output reg [3:0] swEnable,
  output wire seqBusy,
  // current sharing detected per pair
  input wire [1:0] shareDetect,
  // effective switcher settings
  output reg [3:0] swCcm,
  output reg [7:0] swDivSel,
  output reg [19:0] swPhase,
  output reg [27:0] swVref,
  output reg [15:0] swIlimHalfAmps,
  output reg [3:0] faultBlank
);

  // ----------------------------------------------------------------
  // constants and helpers
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_START = 2'd1;
  localparam [1:0] ST_STOP = 2'd2;
  // counts are cut to their counter widths on purpose; both defaults fit
  localparam integer BLANK_INT = BLANK_CYCLES;
  localparam integer STEP_INT = `PMCFG_STEP_CYCLES - 1;
  localparam [14:0] BLANK_LOAD = BLANK_INT[14:0];
  localparam [7:0] STEP_LOAD = STEP_INT[7:0];

  // page whose settings an output follows; slaves follow the master of their pair
  function [1:0] srcPage;
    input [1:0] page;
    input [1:0] share;
    begin
      srcPage = (share[page[1]] && page[0]) ? {page[1], 1'b0} : page;
    end
  endfunction

  // current limit in half-amp units for a page and its code
  function [3:0] ilimDecode;
    input [1:0] page;
    input [2:0] code;
    begin
      if (!page[1]) begin
        ilimDecode = code[2] ? 4'hC : {1'b0, code[1:0], 1'b0} + 4'h4;
      end else begin
        case (code[1:0])
          2'h0: ilimDecode = 4'h1;
          2'h1: ilimDecode = 4'h2;
          2'h2: ilimDecode = 4'h4;
          default: ilimDecode = 4'h6;
        endcase
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // per-page storage
  // ----------------------------------------------------------------
  reg [3:0] seqPosQ [0:3];
  reg [3:0] ccmStoreQ;
  reg [3:0] ccmActQ;
  reg [6:0] divPhStoreQ [0:3];
  reg [6:0] divPhActQ [0:3];
  reg [6:0] vrefTgtQ [0:3];
  reg [6:0] vrefNowQ [0:3];
  reg [2:0] ilimQ [0:3];
  reg [14:0] blankCntQ [0:3];
  reg [7:0] stepCntQ;
  reg [1:0] stateQ;
  reg [1:0] stepQ;
  // one loop index per process, so no two processes share a variable
  integer i;
  integer j;
  integer k;
  integer m;

  wire slaveInvalid = shareDetect[cmdPage[1]] && cmdPage[0];
  wire doWrite = cmdValid && cmdWrite && !slaveInvalid;
  wire slewTick = (stepCntQ == 8'h00);

  // default phase for each page, loaded on every reset
  function [4:0] phaseRst;
    input [1:0] page;
    begin
      case (page)
        2'd0: phaseRst = `PMCFG_PHASE_RST0;
        2'd1: phaseRst = `PMCFG_PHASE_RST1;
        2'd2: phaseRst = `PMCFG_PHASE_RST2;
        default: phaseRst = `PMCFG_PHASE_RST3;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // register writes; stored mode and divider never go live, reset loads the defaults into both copies
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      for (i = 0; i < 4; i = i + 1) begin
        seqPosQ[i] <= `PMCFG_SEQ_RST;
        divPhActQ[i] <= {phaseRst(i[1:0]), `PMCFG_DIV_RST};
        divPhStoreQ[i] <= {phaseRst(i[1:0]), `PMCFG_DIV_RST};
        vrefTgtQ[i] <= `PMCFG_VREF_RST;
        ilimQ[i] <= (i < 2) ? `PMCFG_ILIM_HI_RST : `PMCFG_ILIM_LO_RST;
      end
      ccmStoreQ <= {4{`PMCFG_CCM_RST}};
      ccmActQ <= {4{`PMCFG_CCM_RST}};
    end else if (doWrite) begin
      // writes land in the page that the page selection names
      case (cmdCode)
        `PMCFG_CMD_SEQ_POS: seqPosQ[cmdPage] <= cmdWrData[3:0];
        `PMCFG_CMD_MODE: ccmStoreQ[cmdPage] <= cmdWrData[`PMCFG_CCM_BIT];
        `PMCFG_CMD_DIV_PHASE: divPhStoreQ[cmdPage] <= cmdWrData[6:0];
        `PMCFG_CMD_VREF: vrefTgtQ[cmdPage] <= cmdWrData[6:0];
        `PMCFG_CMD_ILIM: begin
          ilimQ[cmdPage] <= cmdPage[1] ? {1'b0, cmdWrData[1:0]} : cmdWrData[2:0];
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read path; upper bits and unknown codes return zero
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      cmdRdData <= 8'h00;
      cmdRdValid <= 1'b0;
    end else begin
      cmdRdValid <= cmdValid && !cmdWrite;
      if (cmdValid && !cmdWrite) begin
        if (slaveInvalid) begin
          cmdRdData <= 8'h00;
        end else begin
          case (cmdCode)
            `PMCFG_CMD_SEQ_POS: cmdRdData <= {4'h0, seqPosQ[cmdPage]};
            `PMCFG_CMD_MODE: begin
              // share flag is only meaningful from the master page
              cmdRdData <= {6'h00, shareDetect[cmdPage[1]] && !cmdPage[0],
                            ccmStoreQ[cmdPage]};
            end
            `PMCFG_CMD_DIV_PHASE: cmdRdData <= {1'b0, divPhStoreQ[cmdPage]};
            `PMCFG_CMD_VREF: cmdRdData <= {1'b0, vrefTgtQ[cmdPage]};
            `PMCFG_CMD_ILIM: cmdRdData <= {5'h00, ilimQ[cmdPage]};
            default: cmdRdData <= 8'h00;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // effective settings driven to the switchers
  // ----------------------------------------------------------------
  reg [1:0] sp;
  reg [1:0] dv;
  reg [5:0] halfSteps;
  reg [5:0] wrapMask;
  reg [5:0] slavePh;
  always @* begin
    sp = 2'd0;
    dv = 2'd0;
    halfSteps = 6'h00;
    wrapMask = 6'h00;
    slavePh = 6'h00;
    for (k = 0; k < 4; k = k + 1) begin
      sp = srcPage(k[1:0], shareDetect);
      dv = divPhActQ[sp][1:0];
      swCcm[k] = ccmActQ[sp];
      swDivSel[2*k +: 2] = dv;
      // half a switching period is two quarter steps per oscillator period
      halfSteps = 6'h02 << dv;
      wrapMask = (6'h04 << dv) - 6'h01;
      slavePh = ({1'b0, divPhActQ[sp][6:2]} + halfSteps) & wrapMask;
      if (sp != k[1:0]) begin
        swPhase[5*k +: 5] = slavePh[4:0];
      end else begin
        swPhase[5*k +: 5] = divPhActQ[sp][6:2];
      end
      swVref[7*k +: 7] = vrefNowQ[sp];
      swIlimHalfAmps[4*k +: 4] = ilimDecode(k[1:0], ilimQ[sp]);
      faultBlank[k] = (vrefNowQ[sp] != vrefTgtQ[sp]) || (blankCntQ[sp] != 15'h0000);
    end
  end

  // ----------------------------------------------------------------
  // reference slew and fault blanking
  // ----------------------------------------------------------------
  always @(posedge core_clk) begin
    if (rst) begin
      stepCntQ <= STEP_LOAD;
      for (j = 0; j < 4; j = j + 1) begin
        vrefNowQ[j] <= `PMCFG_VREF_RST;
        blankCntQ[j] <= 15'h0000;
      end
    end else begin
      stepCntQ <= slewTick ? STEP_LOAD : stepCntQ - 8'h01;
      for (j = 0; j < 4; j = j + 1) begin
        // one code per tick, so a larger change takes longer
        if (slewTick && vrefNowQ[j] < vrefTgtQ[j]) begin
          vrefNowQ[j] <= vrefNowQ[j] + 7'h01;
        end else if (slewTick && vrefNowQ[j] > vrefTgtQ[j]) begin
          vrefNowQ[j] <= vrefNowQ[j] - 7'h01;
        end
        // blanking restarts while moving and runs out after arrival
        if (vrefNowQ[j] != vrefTgtQ[j]) begin
          blankCntQ[j] <= BLANK_LOAD;
        end else if (blankCntQ[j] != 15'h0000) begin
          blankCntQ[j] <= blankCntQ[j] - 15'h0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // start and stop sequencer
  // ----------------------------------------------------------------
  reg [3:0] enD;
  reg stepDone;
  reg [3:0] posNow;
  always @* begin
    enD = swEnable;
    stepDone = 1'b1;
    posNow = 4'h0;
    for (m = 0; m < 4; m = m + 1) begin
      posNow = seqPosQ[srcPage(m[1:0], shareDetect)];
      if (stateQ == ST_START && posNow[`PMCFG_START_LSB +: 2] == stepQ) begin
        enD[m] = 1'b1;
        // the next step may only begin once this step is good
        if (powerGoodGatingSelect && !powerGoodStatus[m]) begin
          stepDone = 1'b0;
        end
      end
      if (stateQ == ST_STOP && posNow[`PMCFG_STOP_LSB +: 2] == stepQ) begin
        enD[m] = 1'b0;
      end
    end
  end

  assign seqBusy = (stateQ != ST_IDLE);

  // positions are sampled live, so changes mid sequence take effect at once
  always @(posedge core_clk) begin
    if (rst) begin
      stateQ <= ST_IDLE;
      stepQ <= 2'd0;
      swEnable <= 4'h0;
    end else begin
      swEnable <= enD;
      case (stateQ)
        ST_IDLE: begin
          stepQ <= 2'd0;
          if (seqStartReq) begin
            stateQ <= ST_START;
          end else if (seqStopReq) begin
            stateQ <= ST_STOP;
          end
        end
        ST_START: begin
          if (seqStopReq) begin
            stateQ <= ST_STOP;
            stepQ <= 2'd0;
          end else if (stepDone && swEnable == enD) begin
            stepQ <= stepQ + 2'd1;
            if (stepQ == 2'd3) begin
              stateQ <= ST_IDLE;
            end
          end
        end
        ST_STOP: begin
          stepQ <= stepQ + 2'd1;
          if (stepQ == 2'd3) begin
            stateQ <= ST_IDLE;
          end
        end
        default: stateQ <= ST_IDLE;
      endcase
    end
  end

endmodule

// File: bench/pmcfg_bank_sva.sv
// port-level assertions for the output config bank
`timescale 1ns/1ps
module pmcfg_bank_sva (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // command port
  input wire cmdValid,
  input wire cmdWrite,
  input wire [7:0] cmdCode,
  input wire [7:0] cmdRdData,
  input wire cmdRdValid,
  // sequencing and effective settings
  input wire seqStartReq,
  input wire seqStopReq,
  input wire seqBusy,
  input wire [1:0] shareDetect,
  input wire [3:0] swCcm,
  input wire [7:0] swDivSel,
  input wire [19:0] swPhase,
  input wire [27:0] swVref,
  input wire [15:0] swIlimHalfAmps,
  input wire [3:0] faultBlank
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  wire rdReq = cmdValid && !cmdWrite;
  sequence vrefMove;
    $changed(swVref[6:0]);
  endsequence
  sequence vrefHold;
    $stable(swVref[6:0]) [*8];
  endsequence
  a_read_answer: assert property (rdReq |=> cmdRdValid) else $error("read not answered");
  a_unknown_zero: assert property (rdReq && (cmdCode < 8'hD5 || cmdCode > 8'hD9)
    |=> cmdRdData == 8'h00) else $error("unused code read nonzero");
  a_mode_frozen: assert property (!$past(rst) && $stable(shareDetect)
    |-> $stable(swCcm) && $stable(swDivSel)) else $error("mode moved without reset");
  a_vref_spacing: assert property (vrefMove |=> vrefHold) else $error("vref steps too fast");
  a_vref_unit: assert property (vrefMove |-> (swVref[6:0] - $past(swVref[6:0]) == 7'h01)
    || ($past(swVref[6:0]) - swVref[6:0] == 7'h01)) else $error("vref jumped");
  a_blank_move: assert property (vrefMove |-> faultBlank[0]) else $error("fault not blanked");
  a_slave_follow: assert property (shareDetect[0] && $past(shareDetect[0]) |->
    swVref[13:7] == swVref[6:0] && swDivSel[3:2] == swDivSel[1:0] && swCcm[1] == swCcm[0])
    else $error("slave not following master");
  a_slave_phase: assert property (shareDetect[0] && $past(shareDetect[0]) |->
    {1'b0, swPhase[9:5]} == (({1'b0, swPhase[4:0]} + (6'h02 << swDivSel[1:0]))
    & ((6'h04 << swDivSel[1:0]) - 6'h01))) else $error("slave phase not half period");
  a_limit_codes: assert property (swIlimHalfAmps[15:12] inside {4'h1, 4'h2, 4'h4, 4'h6}
    && swIlimHalfAmps[3:0] inside {4'h4, 4'h6, 4'h8, 4'hA, 4'hC})
    else $error("current limit off table");
  a_start_busy: assert property (seqStartReq && !seqStopReq && !seqBusy |=> seqBusy)
    else $error("start not taken");
endmodule
bind pmcfg_bank pmcfg_bank_sva u_sva (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid),
  .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid),
  .seqStartReq(seqStartReq), .seqStopReq(seqStopReq), .seqBusy(seqBusy),
  .shareDetect(shareDetect), .swCcm(swCcm), .swDivSel(swDivSel), .swPhase(swPhase),
  .swVref(swVref), .swIlimHalfAmps(swIlimHalfAmps), .faultBlank(faultBlank));

// File: bench/pmcfg_sw_model.sv
// switcher model: power good follows enable after a settling delay
`timescale 1ns/1ps
module pmcfg_sw_model #(
  parameter PG_DELAY = 6
) (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // switcher side
  input wire [3:0] swEnable,
  output wire [3:0] powerGoodStatus
);
  reg [3:0] pipe_q [0:PG_DELAY-1];
  integer i;
  // ramp delay; power good drops at once on disable, as a real output would
  always @(posedge core_clk) begin
    pipe_q[0] <= rst ? 4'h0 : swEnable;
    for (i = 1; i < PG_DELAY; i = i + 1) begin
      pipe_q[i] <= rst ? 4'h0 : pipe_q[i-1];
    end
  end
  assign powerGoodStatus = pipe_q[PG_DELAY-1] & swEnable;
endmodule

// File: bench/tb_top.sv
// self-checking bench for the output config bank
`timescale 1ns/1ps
module tb_top;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg cmdValid = 1'b0;
  reg cmdWrite = 1'b0;
  reg [7:0] cmdCode = 8'h00;
  reg [1:0] cmdPage = 2'h0;
  reg [7:0] cmdWrData = 8'h00;
  reg seqStartReq = 1'b0;
  reg seqStopReq = 1'b0;
  reg powerGoodGatingSelect = 1'b0;
  reg [1:0] shareDetect = 2'h0;
  wire [7:0] cmdRdData, swDivSel;
  wire cmdRdValid, seqBusy;
  wire [3:0] swEnable, powerGoodStatus, swCcm, faultBlank;
  wire [19:0] swPhase;
  wire [27:0] swVref;
  wire [15:0] swIlimHalfAmps;
  integer n_errors = 0;
  integer check_count = 0;
  integer i, j, k, p, c;
  reg [31:0] rnd = 32'h44EB;
  reg [7:0] code, d;
  reg [1:0] pg;
  reg [3:0] prev;
  always #2.5 core_clk = ~core_clk;
  // short blanking keeps the run brief
  pmcfg_bank #(.BLANK_CYCLES(50)) dut (.core_clk(core_clk), .rst(rst), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWrData(cmdWrData),
    .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .seqStartReq(seqStartReq),
    .seqStopReq(seqStopReq), .powerGoodGatingSelect(powerGoodGatingSelect),
    .powerGoodStatus(powerGoodStatus), .swEnable(swEnable), .seqBusy(seqBusy),
    .shareDetect(shareDetect), .swCcm(swCcm), .swDivSel(swDivSel), .swPhase(swPhase),
    .swVref(swVref), .swIlimHalfAmps(swIlimHalfAmps), .faultBlank(faultBlank));
  pmcfg_sw_model u_sw (.core_clk(core_clk), .rst(rst), .swEnable(swEnable),
    .powerGoodStatus(powerGoodStatus));
  // ------------------------------------------------------------
  // expectation helpers
  // ------------------------------------------------------------
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function [7:0] rmask(input [7:0] cd, input [1:0] pa);
    case (cd)
      8'hD5: rmask = 8'h0F;
      8'hD6: rmask = 8'h01;
      8'hD7, 8'hD8: rmask = 8'h7F;
      8'hD9: rmask = pa[1] ? 8'h03 : 8'h07;
      default: rmask = 8'h00;
    endcase
  endfunction
  function [7:0] rstval(input [7:0] cd, input [1:0] pa);
    case (cd)
      8'hD7: rstval = {4'h0, pa[0], pa[1], 2'h0};
      8'hD8: rstval = 8'h14;
      8'hD9: rstval = pa[1] ? 8'h03 : 8'h04;
      default: rstval = 8'h00;
    endcase
  endfunction
  // limit in half amps; the higher-current pages saturate at 6 A
  function [3:0] ilim(input [2:0] cd, input hi);
    if (hi) ilim = cd[2] ? 4'hC : 4'h4 + {cd[1:0], 1'b0};
    else ilim = cd[1] ? (cd[0] ? 4'h6 : 4'h4) : (cd[0] ? 4'h2 : 4'h1);
  endfunction
  task chk(input [31:0] got, input [31:0] want);
    begin
      check_count = check_count + 1;
      if (got !== want) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, want);
      end
    end
  endtask
  task cmd(input w, input [7:0] cd, input [1:0] pa, input [7:0] dat);
    begin
      @(negedge core_clk);
      cmdValid = 1'b1;
      cmdWrite = w;
      cmdCode = cd;
      cmdPage = pa;
      cmdWrData = dat;
      @(negedge core_clk);
      cmdValid = 1'b0;
    end
  endtask
  task rd(input [7:0] cd, input [1:0] pa, input [7:0] want);
    begin
      cmd(1'b0, cd, pa, 8'h00);
      chk(cmdRdValid, 1'b1);
      chk(cmdRdData, want);
    end
  endtask
  // one sequence run; enables must fill or empty as a prefix of the order
  task runseq(input start, input [3:0] first);
    begin
      @(negedge core_clk);
      seqStartReq = start;
      seqStopReq = !start;
      @(negedge core_clk);
      seqStartReq = 1'b0;
      seqStopReq = 1'b0;
      prev = swEnable;
      for (i = 0; i < 300 && (i < 2 || seqBusy === 1'b1); i = i + 1) begin
        @(negedge core_clk);
        if (i == 0 && start) chk(swEnable, first);
        chk(swEnable & (swEnable + 4'h1), 4'h0);
        for (j = 1; j < 4; j = j + 1) begin
          if (powerGoodGatingSelect && swEnable[j] && !prev[j]) chk(powerGoodStatus[j-1], 1'b1);
        end
        prev = swEnable;
      end
      chk(swEnable, start ? 4'hF : 4'h0);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
    for (p = 0; p < 4; p = p + 1) begin
      for (c = 8'hD5; c <= 8'hDA; c = c + 1) rd(c[7:0], p[1:0], rstval(c[7:0], p[1:0]));
    end
    chk(swIlimHalfAmps, 16'h66CC);
    chk(swPhase, 20'h18440);
    chk(swVref, {4{7'h14}});
    $display("test reset values done");
    for (k = 0; k < 40; k = k + 1) begin
      rnd = lfsr(rnd);
      code = (rnd[9:8] == 2'h3) ? 8'hD9 : 8'hD5 + {6'h00, rnd[9:8]};
      pg = rnd[1:0];
      d = (k == 0) ? 8'hFF : rnd[23:16];
      cmd(1'b1, code, pg, d);
      rd(code, pg, d & rmask(code, pg));
      if (code == 8'hD9) chk(swIlimHalfAmps[pg*4 +: 4], ilim(d[2:0], !pg[1]));
    end
    chk({swCcm, swDivSel}, 12'h000);
    $display("test random access done");
    shareDetect = 2'h3;
    cmd(1'b1, 8'hD6, 2'h0, 8'h01);
    rd(8'hD6, 2'h0, 8'h03);
    rd(8'hD8, 2'h1, 8'h00);
    cmd(1'b1, 8'hD8, 2'h3, 8'h55);
    shareDetect = 2'h0;
    rd(8'hD8, 2'h3, 8'h14);
    $display("test sharing done");
    cmd(1'b1, 8'hD8, 2'h0, 8'h17);
    @(negedge core_clk);
    chk(faultBlank[0], 1'b1);
    for (i = 0; i < 1000 && swVref[6:0] !== 7'h17; i = i + 1) @(negedge core_clk);
    chk(i > 350, 1'b1);
    repeat (40) @(negedge core_clk);
    chk(faultBlank[0], 1'b1);
    repeat (20) @(negedge core_clk);
    chk(faultBlank[0], 1'b0);
    $display("test reference slew done");
    powerGoodGatingSelect = 1'b1;
    // positions are rewritten only while the sequencer is idle
    for (p = 0; p < 4; p = p + 1) cmd(1'b1, 8'hD5, p[1:0], {4'h0, 2'h3 - p[1:0], p[1:0]});
    runseq(1'b1, 4'h1);
    runseq(1'b0, 4'h0);
    powerGoodGatingSelect = 1'b0;
    for (p = 0; p < 4; p = p + 1) cmd(1'b1, 8'hD5, p[1:0], 8'h00);
    runseq(1'b1, 4'hF);
    runseq(1'b0, 4'h0);
    $display("test sequencing done");
    give_verdict;
  end
  // watchdog well beyond the thousand or so cycles the tests need
  initial begin
    #100000;
    n_errors = n_errors + 1;
    give_verdict;
  end
endmodule
